/* File: hw/sya_pkg.sv */
// Constants shared by the sync serial adapter design.
// Assumes one core clock domain; the link clock is sampled, not used as clock.
package sya_pkg;
    // Register reset values (both section resets held after reset)
    localparam logic [7:0] C1_RST = 8'h03;
    localparam logic [7:0] C2_RST = 8'h00;
    localparam logic [1:0] C3_RST = 2'h0;
    localparam logic [7:0] SYNC_RST = 8'h00;
    // Control 1 bit positions
    localparam int C1_RXRS = 0;
    localparam int C1_TXRS = 1;
    localparam int C1_STRIP = 2;
    localparam int C1_CLRSYNC = 3;
    localparam int C1_AC1 = 6;
    localparam int C1_AC2 = 7;
    // Control 2 bit positions
    localparam int C2_ONEBYTE = 2;
    localparam int C2_WS_LO = 3;
    localparam int C2_TXSYNC = 6;
    // Control 3 bit positions
    localparam int C3_EXT = 0;
    localparam int C3_ONE = 1;
    localparam int C3_CLRCTS = 2;
    localparam int C3_CLEAR_UNDERFLOW_CMD = 3;
    // Write select codes, {addr_ctl_high, addr_ctl_low}
    localparam logic [1:0] AC_C2 = 2'h0;
    localparam logic [1:0] AC_C3 = 2'h1;
    localparam logic [1:0] AC_SYNC = 2'h2;
    localparam logic [1:0] AC_TX = 2'h3;
    // Status bit positions
    localparam int ST_RDA = 0;
    localparam int ST_TRANSMIT_REGISTER_AVAILABLE = 1;
    localparam int ST_DCD = 2;
    localparam int ST_CTS = 3;
    localparam int ST_TUF = 4;
    localparam int ST_OVRN = 5;
    localparam int ST_PE = 6;
    // Queue geometry
    localparam int STAGES = 3;
    localparam int DW = 8;
    // Receiver character synchronisation states
    typedef enum logic [1:0] {
        SY_HUNT = 2'b00,
        SY_SECOND = 2'b01,
        SY_LOCKED = 2'b10
    } sya_sync_t;
endpackage : sya_pkg

/* File: hw/sya_adapter.sv */
// Sync serial adapter: host register port, receiver sync, staged queues.
// Assumes host accesses are one-cycle bus_en strobes on core_clk and that
// line_clk, rx_serial, cts_in and dcd_in are asynchronous pins.
// How it works
// - Reset selects internal sync mode
// - One-sync mode locks on single match
// - Two-sync mode needs two; miss resumes hunt
// - Clear-handshake command drops latched status only
// - Clear-underflow command resets underflow status
// - Sync pattern written at select code two
// - External mode: pattern only matches and fills
// - First match pulses sync-match output
// - Sync fill carries parity only nine-bit format
// - Acquisition sync characters discarded, unchecked
// - Strip drops sync matches; else checked data
// - Three stages per queue (receive stages nine bits), data ripples forward
// - Overrun overwrites stage one, sticky flag
// - Unused receive bits read as zero
// - Transmit masks upper bits, makes parity
// - Underflow sends fill, latches, pulses output
// - Status read-only, reading clears nothing
// - Receive available from stage three/two
// - Transmit available from stage one/two
// - Transmit reset inhibits available, flushes queue
// - Clear-to-send inhibits available in internal modes
// - Carrier rise latched until read pair
`timescale 1ns/1ns

// Staged queue: each full stage moves into an empty neighbour every clock
module sya_stage_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic overwrite,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [DEPTH-1:0] full
);
    logic [DEPTH-1:0] full_reg, full_next;
    logic [WIDTH-1:0] data_reg [DEPTH];
    logic [WIDTH-1:0] data_next [DEPTH];

    assign in_ready = !full_reg[0];
    assign out_valid = full_reg[DEPTH-1];
    assign out_data = data_reg[DEPTH-1];
    assign full = full_reg;

    // Ripple toward the output; a popped last stage refills next clock
    always_comb begin
        full_next = full_reg;
        data_next = data_reg;
        if (out_ready && full_reg[DEPTH-1]) begin
            full_next[DEPTH-1] = 1'b0;
        end
        for (int i = DEPTH - 2; i >= 0; i--) begin
            if (full_reg[i] && !full_reg[i+1]) begin
                full_next[i+1] = 1'b1;
                full_next[i] = 1'b0;
                data_next[i+1] = data_reg[i];
            end
        end
        if (in_valid && (!full_reg[0] || overwrite)) begin
            full_next[0] = 1'b1;
            data_next[0] = in_data;
        end
        if (flush) begin
            full_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            full_reg <= '0;
        end else begin
            full_reg <= full_next;
        end
        data_reg <= data_next;
    end
endmodule : sya_stage_fifo

module sya_adapter (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Host register port
    input wire logic bus_en,
    input wire logic register_select,
    input wire logic bus_rw,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    // Serial line
    input wire logic line_clk,
    input wire logic rx_serial,
    input wire logic cts_in,
    input wire logic dcd_in,
    output logic tx_serial,
    output logic sync_match_output,
    output logic underflow_flag
);
    logic [7:0] c1_reg, c1_next, c2_reg, c2_next, sync_pattern_reg;
    logic [7:0] sync_pattern_next, rdata_reg, rdata_next;
    logic [1:0] c3_reg, c3_next;
    logic [3:0] s1_reg, s2_reg;
    logic [2:0] prev_reg;
    sya_pkg::sya_sync_t state_reg, state_next;
    logic [8:0] rx_sh_reg, rx_sh_next, tx_sh_reg, tx_sh_next, aligned;
    logic [3:0] rx_cnt_reg, rx_cnt_next, tx_cnt_reg, tx_cnt_next;
    logic sm_reg, sm_next, tx_out_reg, tx_out_next, uf_out_reg, uf_out_next;
    logic uf_pend_reg, uf_pend_next, ovrn_reg, ovrn_next, seen_reg, seen_next;
    logic dcd_lat_reg, dcd_lat_next, cts_lat_reg, cts_lat_next;
    logic tuf_reg, tuf_next;
    // Decoded controls and events
    logic [2:0] ws;
    logic [3:0] db, char_len, scl;
    logic [7:0] dmask, smask, status;
    logic par_en, par_odd, ext, one_sync, one_byte, receiver_reset_bit, transmitter_reset_bit, strip;
    logic st_rd, fifo_rd, wr, wr_c3, lrise, lfall, dcd_rise, cts_rise;
    logic match, rx_push, ovrn_set, tuf_set, clr_rx, receive_data_available, transmit_register_available;
    logic rx_valid, tx_valid, tx_pop, tx_flush, tx_wr;
    localparam int STG = sya_pkg::STAGES;
    logic [8:0] rx_out;
    logic [7:0] tx_out_data;
    logic [STG-1:0] rx_full, tx_full;

    assign bus_rdata = rdata_reg;
    assign tx_serial = tx_out_reg;
    assign sync_match_output = sm_reg;
    assign underflow_flag = uf_out_reg;

    // Word format decode; sync length is the character length, eight bits in nine-bit formats
    always_comb begin
        ws = c2_reg[sya_pkg::C2_WS_LO +: 3];
        case (ws)
            3'h0, 3'h1: db = 4'h6;
            3'h2, 3'h4, 3'h5: db = 4'h7;
            default: db = 4'h8;
        endcase
        par_en = (ws != 3'h2) && (ws != 3'h3);
        par_odd = ws[0];
        char_len = db + {3'h0, par_en};
        scl = (ws[2:1] == 2'h3) ? 4'h8 : char_len;
        dmask = 8'((9'h001 << db) - 9'h001);
        smask = 8'((9'h001 << scl) - 9'h001);
    end

    // Host strobes and mode bits
    always_comb begin
        st_rd = bus_en && !register_select && bus_rw;
        fifo_rd = bus_en && register_select && bus_rw;
        wr = bus_en && register_select && !bus_rw;
        wr_c3 = wr && ({c1_reg[sya_pkg::C1_AC2], c1_reg[sya_pkg::C1_AC1]}
            == sya_pkg::AC_C3);
        tx_wr = wr && ({c1_reg[sya_pkg::C1_AC2], c1_reg[sya_pkg::C1_AC1]}
            == sya_pkg::AC_TX);
        // Flush only on the reset write, so the queue can be preloaded
        tx_flush = bus_en && !register_select && !bus_rw
            && bus_wdata[sya_pkg::C1_TXRS];
        ext = c3_reg[sya_pkg::C3_EXT];
        one_sync = c3_reg[sya_pkg::C3_ONE];
        one_byte = c2_reg[sya_pkg::C2_ONEBYTE];
        receiver_reset_bit = c1_reg[sya_pkg::C1_RXRS];
        transmitter_reset_bit = c1_reg[sya_pkg::C1_TXRS];
        strip = c1_reg[sya_pkg::C1_STRIP];
        lrise = s2_reg[0] && !prev_reg[0];
        lfall = !s2_reg[0] && prev_reg[0];
        dcd_rise = s2_reg[3] && !prev_reg[2];
        cts_rise = s2_reg[2] && !prev_reg[1];
    end

    // Receive queue: nine bits, parity error rides with each character
    sya_stage_fifo #(.WIDTH(sya_pkg::DW + 1), .DEPTH(STG)) u_rxq (
        .clk(core_clk),
        .rst_b(rst_b),
        .flush(receiver_reset_bit),
        .in_valid(rx_push),
        .in_ready(),
        .overwrite(1'b1),
        .in_data({ (par_en && aligned[db] != (par_odd ?
            ~^(aligned[7:0] & dmask) : ^(aligned[7:0] & dmask))),
            aligned[7:0] & dmask }),
        .out_valid(rx_valid),
        .out_ready(fifo_rd),
        .out_data(rx_out),
        .full(rx_full)
    );

    // Transmit queue; host writes to a full first stage are dropped
    sya_stage_fifo #(.WIDTH(sya_pkg::DW), .DEPTH(STG)) u_txq (
        .clk(core_clk),
        .rst_b(rst_b),
        .flush(tx_flush),
        .in_valid(tx_wr),
        .in_ready(),
        .overwrite(1'b0),
        .in_data(bus_wdata),
        .out_valid(tx_valid),
        .out_ready(tx_pop),
        .out_data(tx_out_data),
        .full(tx_full)
    );

    // Host-visible availability and status byte; top bit has no source
    always_comb begin
        receive_data_available = one_byte ? rx_full[2] : (rx_full[1] && rx_full[2]);
        transmit_register_available = !transmitter_reset_bit && !(s2_reg[2] && !ext)
            && (one_byte ? !tx_full[0] : !tx_full[0] && !tx_full[1]);
        status = 8'h00;
        status[sya_pkg::ST_RDA] = receive_data_available;
        status[sya_pkg::ST_TRANSMIT_REGISTER_AVAILABLE] = transmit_register_available;
        status[sya_pkg::ST_DCD] = dcd_lat_reg || s2_reg[3];
        status[sya_pkg::ST_CTS] = cts_lat_reg || s2_reg[2];
        status[sya_pkg::ST_TUF] = tuf_reg;
        status[sya_pkg::ST_OVRN] = ovrn_reg;
        status[sya_pkg::ST_PE] = rx_valid && rx_out[8];
    end

    // Registers, sticky flags and read data; a set beats a clear
    always_comb begin
        c1_next = c1_reg;
        c2_next = c2_reg;
        c3_next = c3_reg;
        sync_pattern_next = sync_pattern_reg;
        rdata_next = rdata_reg;
        if (bus_en && !register_select && !bus_rw) begin
            c1_next = bus_wdata;
        end
        if (wr) begin
            case ({c1_reg[sya_pkg::C1_AC2], c1_reg[sya_pkg::C1_AC1]})
                sya_pkg::AC_C2: c2_next = bus_wdata;
                sya_pkg::AC_C3: c3_next = bus_wdata[1:0];
                sya_pkg::AC_SYNC: sync_pattern_next = bus_wdata;
                default: c2_next = c2_reg;
            endcase
        end
        if (st_rd) begin
            rdata_next = status;
        end else if (fifo_rd) begin
            rdata_next = rx_valid ? rx_out[7:0] & dmask : 8'h00;
        end
        seen_next = st_rd ? 1'b1 : (fifo_rd ? 1'b0 : seen_reg);
        clr_rx = fifo_rd && seen_reg;
        ovrn_next = ovrn_set || (ovrn_reg && !(clr_rx || receiver_reset_bit));
        dcd_lat_next = dcd_rise
            || (dcd_lat_reg && !(clr_rx || receiver_reset_bit));
        cts_lat_next = cts_rise || (cts_lat_reg
            && !((wr_c3 && bus_wdata[sya_pkg::C3_CLRCTS]) || transmitter_reset_bit));
        tuf_next = tuf_set || (tuf_reg
            && !((wr_c3 && bus_wdata[sya_pkg::C3_CLEAR_UNDERFLOW_CMD]) || transmitter_reset_bit));
    end

    // Receiver: bit-by-bit hunt, then character framing
    always_comb begin
        rx_sh_next = rx_sh_reg;
        rx_cnt_next = rx_cnt_reg;
        state_next = state_reg;
        sm_next = 1'b0;
        rx_push = 1'b0;
        aligned = ({s2_reg[1], rx_sh_reg[8:1]}) >> (4'h9 - char_len);
        match = (aligned[7:0] & smask) == (sync_pattern_reg & smask);
        ovrn_set = 1'b0;
        if (receiver_reset_bit || c1_reg[sya_pkg::C1_CLRSYNC]) begin
            state_next = sya_pkg::SY_HUNT;
            rx_cnt_next = 4'h0;
            rx_sh_next = 9'h1ff;
        end else if (ext && state_reg != sya_pkg::SY_LOCKED) begin
            if (s2_reg[3]) begin
                state_next = sya_pkg::SY_LOCKED;
                rx_cnt_next = 4'h0;
            end
        end else if (ext && !s2_reg[3]) begin
            state_next = sya_pkg::SY_HUNT;
        end else if (lrise) begin
            rx_sh_next = {s2_reg[1], rx_sh_reg[8:1]};
            rx_cnt_next = rx_cnt_reg + 4'h1;
            case (state_reg)
                sya_pkg::SY_HUNT: begin
                    rx_cnt_next = 4'h0;
                    if (match) begin
                        sm_next = 1'b1;
                        state_next = one_sync ? sya_pkg::SY_LOCKED
                            : sya_pkg::SY_SECOND;
                    end
                end
                sya_pkg::SY_SECOND: begin
                    if (rx_cnt_next == char_len) begin
                        rx_cnt_next = 4'h0;
                        state_next = match ? sya_pkg::SY_LOCKED
                            : sya_pkg::SY_HUNT;
                    end
                end
                sya_pkg::SY_LOCKED: begin
                    if (rx_cnt_next == char_len) begin
                        rx_cnt_next = 4'h0;
                        rx_push = !(strip && match);
                        ovrn_set = rx_push && rx_full[0] && rx_full[1];
                    end
                end
                default: state_next = sya_pkg::SY_HUNT;
            endcase
        end
    end

    // Transmitter: shift on link clock fall, fill on underflow
    always_comb begin
        tx_sh_next = tx_sh_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_out_next = tx_out_reg;
        uf_out_next = uf_out_reg;
        uf_pend_next = uf_pend_reg;
        tx_pop = 1'b0;
        tuf_set = 1'b0;
        if (lrise && uf_pend_reg) begin
            uf_out_next = 1'b1;
            uf_pend_next = 1'b0;
        end
        if (transmitter_reset_bit) begin
            tx_sh_next = 9'h1ff;
            tx_cnt_next = 4'h0;
            tx_out_next = 1'b1;
            uf_pend_next = 1'b0;
        end else if (lfall) begin
            uf_out_next = 1'b0;
            if (tx_cnt_reg != 4'h0) begin
                tx_out_next = tx_sh_reg[0];
                tx_sh_next = tx_sh_reg >> 1;
                tx_cnt_next = tx_cnt_reg - 4'h1;
            end else begin
                tx_cnt_next = char_len - 4'h1;
                if (tx_valid) begin
                    tx_pop = 1'b1;
                    tx_sh_next = {1'b0, tx_out_data & dmask}
                        | (9'(par_en && (par_odd ? ~^(tx_out_data & dmask)
                        : ^(tx_out_data & dmask))) << db);
                end else if (c2_reg[sya_pkg::C2_TXSYNC]) begin
                    tuf_set = 1'b1;
                    uf_pend_next = 1'b1;
                    tx_sh_next = {1'b0, sync_pattern_reg & smask}
                        | (9'(ws[2:1] == 2'h3 && (par_odd ?
                        ~^sync_pattern_reg : ^sync_pattern_reg)) << 8);
                end else begin
                    tx_sh_next = 9'h1ff;
                end
                tx_out_next = tx_sh_next[0];
                tx_sh_next = tx_sh_next >> 1;
            end
        end
    end

    // State registers; synchroniser first stage feeds only the second
    always_ff @(posedge core_clk) begin
        s1_reg <= {dcd_in, cts_in, rx_serial, line_clk};
        s2_reg <= s1_reg;
        prev_reg <= {s2_reg[3], s2_reg[2], s2_reg[0]};
        rx_sh_reg <= rx_sh_next;
        tx_sh_reg <= tx_sh_next;
        if (!rst_b) begin
            c1_reg <= sya_pkg::C1_RST;
            c2_reg <= sya_pkg::C2_RST;
            c3_reg <= sya_pkg::C3_RST;
            sync_pattern_reg <= sya_pkg::SYNC_RST;
            rdata_reg <= 8'h00;
            state_reg <= sya_pkg::SY_HUNT;
            {rx_cnt_reg, tx_cnt_reg} <= 8'h00;
            {sm_reg, uf_out_reg, uf_pend_reg, ovrn_reg} <= 4'h0;
            {seen_reg, dcd_lat_reg, cts_lat_reg, tuf_reg} <= 4'h0;
            tx_out_reg <= 1'b1;
        end else begin
            c1_reg <= c1_next;
            c2_reg <= c2_next;
            c3_reg <= c3_next;
            sync_pattern_reg <= sync_pattern_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            {rx_cnt_reg, tx_cnt_reg} <= {rx_cnt_next, tx_cnt_next};
            {sm_reg, uf_out_reg, uf_pend_reg} <=
                {sm_next, uf_out_next, uf_pend_next};
            {ovrn_reg, seen_reg} <= {ovrn_next, seen_next};
            {dcd_lat_reg, cts_lat_reg, tuf_reg} <=
                {dcd_lat_next, cts_lat_next, tuf_next};
            tx_out_reg <= tx_out_next;
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_ext_reset;
        @(posedge core_clk) disable iff (1'b0) !rst_b |=> !ext;
    endproperty
    a_ext_reset: assert property (p_ext_reset)
        else $error("sync mode not internal after reset");
    property p_one_lock;
        state_reg == sya_pkg::SY_HUNT && sm_next && one_sync && !ext
            |=> state_reg == sya_pkg::SY_LOCKED && sm_reg;
    endproperty
    a_one_lock: assert property (p_one_lock)
        else $error("single sync match did not lock");
    property p_two_sync;
        state_reg == sya_pkg::SY_HUNT && sm_next && !one_sync
            |=> state_reg == sya_pkg::SY_SECOND;
    endproperty
    a_two_sync: assert property (p_two_sync)
        else $error("two sync mode locked on first match");
    property p_clear_underflow_cmd;
        wr_c3 && bus_wdata[sya_pkg::C3_CLEAR_UNDERFLOW_CMD] && !tuf_set |=> !tuf_reg;
    endproperty
    a_clear_underflow_cmd: assert property (p_clear_underflow_cmd)
        else $error("underflow status not cleared");
    property p_ovrn;
        ovrn_set ##1 (!(fifo_rd && seen_reg) && !receiver_reset_bit) [*2] |=> ovrn_reg;
    endproperty
    a_ovrn: assert property (p_ovrn)
        else $error("overrun flag lost");
    property p_rd_zero;
        fifo_rd |=> (rdata_reg & ~$past(dmask)) == 8'h00;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("unused receive bits not zero");
    property p_st_keep;
        st_rd && ovrn_reg && !receiver_reset_bit |=> ovrn_reg;
    endproperty
    a_st_keep: assert property (p_st_keep)
        else $error("status read cleared overrun");
    property p_rda;
        receive_data_available |-> rx_full[2] && rx_valid;
    endproperty
    a_rda: assert property (p_rda)
        else $error("receive available with empty last stage");
    property p_transmit_register_available;
        transmit_register_available |-> !tx_full[0] && !transmitter_reset_bit;
    endproperty
    a_transmit_register_available: assert property (p_transmit_register_available)
        else $error("transmit available with full first stage");
    property p_cts_inh;
        s2_reg[2] && !ext |-> !status[sya_pkg::ST_TRANSMIT_REGISTER_AVAILABLE];
    endproperty
    a_cts_inh: assert property (p_cts_inh)
        else $error("clear-to-send did not inhibit available");
    property p_dcd;
        dcd_rise |=> dcd_lat_reg ##0 status[sya_pkg::ST_DCD];
    endproperty
    a_dcd: assert property (p_dcd)
        else $error("carrier rise not latched");
    property p_uf;
        $rose(uf_out_reg) |-> tuf_reg && c2_reg[sya_pkg::C2_TXSYNC];
    endproperty
    a_uf: assert property (p_uf)
        else $error("underflow pulse without status");

    property p_cv_lock;
        state_reg == sya_pkg::SY_SECOND ##[1:200]
            state_reg == sya_pkg::SY_LOCKED;
    endproperty
    c_lock: cover property (p_cv_lock);
    property p_cv_ovrn;
        ovrn_set;
    endproperty
    c_ovrn: cover property (p_cv_ovrn);
    property p_cv_uf;
        $rose(uf_out_reg);
    endproperty
    c_uf: cover property (p_cv_uf);
endmodule : sya_adapter

/* File: bench/sya_line_model.sv */
// Far end of the sync serial link: clock source and character stream.
// Assumes the adapter samples line_clk with its own core clock.
`timescale 1ns/1ns

module sya_line_model (
    // Link pins
    output logic line_clk,
    output logic rx_serial,
    input wire logic tx_serial,
    // Character sent whenever nothing is queued
    input wire logic [7:0] fill_code
);
    logic [7:0] send_q[$];
    logic [7:0] cur;
    logic [7:0] tx_win = 8'hFF;

    // Last eight transmitted bits, taken mid-bit on the rising edge
    always @(posedge line_clk) begin
        tx_win <= {tx_serial, tx_win[7:1]};
    end

    // Sync links carry fill between data, so the clock runs without pause
    initial begin
        line_clk = 1'b0;
        forever #400 line_clk = ~line_clk;
    end

    // One character per frame, LSB first, bits change on the falling edge
    initial begin
        rx_serial = 1'b1;
        forever begin
            if (send_q.size() > 0) begin
                cur = send_q.pop_front();
            end else begin
                cur = fill_code;
            end
            for (int i = 0; i < 8; i++) begin
                @(negedge line_clk);
                rx_serial = cur[i];
            end
        end
    end
endmodule : sya_line_model

/* File: bench/tb_top.sv */
// Self-checking bench for the sync serial adapter.
// Assumes the line model drives the link and host strobes last one cycle.
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("unexpected %0t: got %h want %h", $time, got, exp); \
        end \
    end

module tb_top;
    localparam logic [7:0] SYNC_CODE = 8'h16;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic bus_en = 1'b0;
    logic register_select = 1'b0;
    logic bus_rw = 1'b1;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic line_clk;
    logic rx_serial;
    logic cts_in = 1'b0;
    logic dcd_in = 1'b0;
    logic tx_serial;
    logic sync_match_output;
    logic underflow_flag;
    logic [7:0] c1_base;
    logic [7:0] st;
    logic [7:0] rd;
    logic [7:0] dat[4];
    logic seen;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;

    // Clock and timeout watchdog
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    sya_adapter u_dut (.core_clk(core_clk), .rst_b(rst_b), .bus_en(bus_en),
        .register_select(register_select), .bus_rw(bus_rw),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .line_clk(line_clk),
        .rx_serial(rx_serial), .cts_in(cts_in), .dcd_in(dcd_in),
        .tx_serial(tx_serial), .sync_match_output(sync_match_output),
        .underflow_flag(underflow_flag));
    sya_line_model u_line (.line_clk(line_clk), .rx_serial(rx_serial),
        .tx_serial(tx_serial), .fill_code(SYNC_CODE));

    // One host access; read data is taken once it has surely landed
    task automatic bus_op(input logic rs, input logic rw,
            input logic [7:0] wd, output logic [7:0] rdv);
        @(negedge core_clk);
        bus_en = 1'b1;
        register_select = rs;
        bus_rw = rw;
        bus_wdata = wd;
        @(negedge core_clk);
        bus_en = 1'b0;
        @(negedge core_clk);
        rdv = bus_rdata;
    endtask : bus_op

    // Select code goes into control 1, then the selected register is written
    task automatic wr_sel(input logic [1:0] ac, input logic [7:0] v);
        logic [7:0] dummy;
        bus_op(1'b0, 1'b0, {ac, c1_base[5:0]}, dummy);
        bus_op(1'b1, 1'b0, v, dummy);
    endtask : wr_sel

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        void'($urandom(32'h3888729b));
        repeat (16) @(negedge core_clk);
        rst_b = 1'b1;
        // Sections held in reset: nothing flagged, transmit inhibited
        bus_op(1'b0, 1'b1, 8'h00, st);
        `CHK(st, 8'h00)
        $display("test reset done");
        // Configure while both sections are held; strip mode on
        c1_base = 8'h07;
        wr_sel(sya_pkg::AC_SYNC, SYNC_CODE);
        wr_sel(sya_pkg::AC_C3, 8'h02);
        wr_sel(sya_pkg::AC_C2, 8'h1C);
        c1_base = 8'h04;
        bus_op(1'b0, 1'b0, {sya_pkg::AC_C3, c1_base[5:0]}, rd);
        seen = 1'b0;
        for (int i = 0; i < 600 && !seen; i++) begin
            @(negedge core_clk);
            seen = (sync_match_output === 1'b1);
        end
        `CHK(seen, 1'b1)
        repeat (200) @(negedge core_clk);
        bus_op(1'b0, 1'b1, 8'h00, st);
        `CHK(st[1:0], 2'b10)
        $display("test sync done");
        // Clear-to-send gates availability; its latch drops on command
        cts_in = 1'b1;
        repeat (8) @(negedge core_clk);
        bus_op(1'b0, 1'b1, 8'h00, st);
        `CHK(st[3:1], 3'b100)
        cts_in = 1'b0;
        repeat (8) @(negedge core_clk);
        bus_op(1'b0, 1'b1, 8'h00, st);
        `CHK(st[3:1], 3'b101)
        wr_sel(sya_pkg::AC_C3, 8'h06);
        bus_op(1'b0, 1'b1, 8'h00, st);
        `CHK(st[3], 1'b0)
        $display("test handshake done");
        // Four random bytes into a three-stage queue: fourth overwrites third
        for (int i = 0; i < 4; i++) begin
            dat[i] = 8'($urandom);
            if (dat[i] == SYNC_CODE) begin
                dat[i] = dat[i] ^ 8'h01;
            end
            u_line.send_q.push_back(dat[i]);
        end
        for (int i = 0; i < 2000 && u_line.send_q.size() > 0; i++) begin
            @(negedge core_clk);
        end
        repeat (160) @(negedge core_clk);
        dcd_in = 1'b1;
        repeat (8) @(negedge core_clk);
        dcd_in = 1'b0;
        repeat (8) @(negedge core_clk);
        bus_op(1'b0, 1'b1, 8'h00, st);
        `CHK(st & 8'h65, 8'h25)
        bus_op(1'b1, 1'b1, 8'h00, rd);
        `CHK(rd, dat[0])
        bus_op(1'b0, 1'b1, 8'h00, st);
        `CHK(st & 8'h25, 8'h01)
        bus_op(1'b1, 1'b1, 8'h00, rd);
        `CHK(rd, dat[1])
        bus_op(1'b1, 1'b1, 8'h00, rd);
        `CHK(rd, dat[3])
        bus_op(1'b0, 1'b1, 8'h00, st);
        `CHK(st[0], 1'b0)
        $display("test overrun done");
        // Two-sync mode: resync, then a data byte still arrives intact
        wr_sel(sya_pkg::AC_C3, 8'h00);
        bus_op(1'b0, 1'b0, 8'h4C, rd);
        bus_op(1'b0, 1'b0, 8'h44, rd);
        seen = 1'b0;
        for (int i = 0; i < 600 && !seen; i++) begin
            @(negedge core_clk);
            seen = (sync_match_output === 1'b1);
        end
        `CHK(seen, 1'b1)
        repeat (200) @(negedge core_clk);
        dat[2] = 8'($urandom) | 8'h80;
        u_line.send_q.push_back(dat[2]);
        repeat (300) @(negedge core_clk);
        bus_op(1'b1, 1'b1, 8'h00, rd);
        `CHK(rd, dat[2])
        $display("test two sync done");
        // Queued byte goes out LSB first between all-ones fill
        dat[0] = 8'($urandom) & 8'hFE;
        wr_sel(sya_pkg::AC_TX, dat[0]);
        seen = 1'b0;
        for (int i = 0; i < 300 && !seen; i++) begin
            @(negedge core_clk);
            seen = (u_line.tx_win === dat[0]);
        end
        `CHK(seen, 1'b1)
        $display("test transmit done");
        // Empty transmit queue with sync fill enabled underflows
        wr_sel(sya_pkg::AC_C2, 8'h5C);
        seen = 1'b0;
        for (int i = 0; i < 400 && !seen; i++) begin
            @(negedge core_clk);
            seen = (underflow_flag === 1'b1);
        end
        `CHK(seen, 1'b1)
        bus_op(1'b0, 1'b1, 8'h00, st);
        bus_op(1'b0, 1'b1, 8'h00, st);
        `CHK(st[4], 1'b1)
        wr_sel(sya_pkg::AC_C3, 8'h0A);
        bus_op(1'b0, 1'b1, 8'h00, st);
        `CHK(st[4], 1'b0)
        $display("test underflow done");
        print_verdict();
    end
endmodule : tb_top
